// *** logic/clkctl_map.svh ***
`ifndef CLKCTL_MAP_SVH
`define CLKCTL_MAP_SVH

// register byte offsets on the bus
`define ADDR_OSC_CTRL      12'h000
`define ADDR_CLK_DIV       12'h004
`define ADDR_PLL_FBD       12'h008
`define ADDR_RC_TUNE       12'h00C
`define ADDR_UNLOCK        12'h010
`define ADDR_AUX_CTRL      12'h014
`define ADDR_REF_CTRL      12'h018

// unlock keys: key1, then key2 or key3, written in order to the unlock register
`define UNLOCK_KEY1        16'h0046
`define UNLOCK_KEY2        16'h0057
`define UNLOCK_KEY3        16'h009A

// oscillator control fields
`define OSC_CUR_LSB        12
`define OSC_REQ_LSB        8
`define OSC_SWLOCK_BIT     7
`define OSC_PLLLOCK_BIT    5
`define OSC_FAIL_BIT       3
`define OSC_SWREQ_BIT      0

// clock divisor fields and reset
`define DIV_ROI_BIT        15
`define DIV_RED_LSB        12
`define DIV_REDEN_BIT      11
`define DIV_POSTSC_LSB     8
`define DIV_PLL_OUTPUT_DIVIDER_LSB    6
`define DIV_PLL_INPUT_DIVIDER_LSB     0
`define DIV_RESET          16'h3040
`define DIV_WMASK          16'hFFDF
`define FBD_RESET          9'h030
`define FBD_WMASK          16'h01FF
`define TUNE_WMASK         16'h003F

// aux / reference control write masks
`define AUX_WMASK          16'hA7C0
`define AUX_RESET          16'h2700
`define REF_WMASK          16'hBF00

// switch timing: 10 new-source cycles before change-over
`define SWITCH_SETTLE      4'd10
// monitor configuration: switching on, failure monitor off
`define CFG_SW_NO_MON      2'b01

`endif

// *** logic/clkctl_pkg.sv ***
package clkctl_pkg;
	typedef enum logic [2:0] {
		SRC_FAST_RC     = 3'h0,
		SRC_FAST_RC_PLL = 3'h1,
		SRC_PRIMARY     = 3'h2,
		SRC_PRIMARY_PLL = 3'h3,
		SRC_SECONDARY   = 3'h4,
		SRC_LOW_PWR_RC  = 3'h5,
		SRC_FAST_RC_16  = 3'h6,
		SRC_FAST_RC_N   = 3'h7
	} src_t;

	typedef enum logic [3:0] {
		SW_IDLE   = 4'b0001,
		SW_WAIT   = 4'b0010,
		SW_SETTLE = 4'b0100,
		SW_DONE   = 4'b1000
	} sw_state_t;

	typedef enum logic [2:0] {
		UL_NONE = 3'b001,
		UL_ONE  = 3'b010,
		UL_OPEN = 3'b100
	} unlock_t;
endpackage : clkctl_pkg

// *** logic/clock_control.sv ***
// Function
// RL1 - auxiliary PLL multiplies input by sixteen
// RL2 - auxiliary PLL input: primary or fast RC
// RL3 - reference output from system or crystal, divided
// RL4 - read-only current source code field
// RL5 - writable requested source code field
// RL6 - power-on loads source codes from configuration
// RL7 - switch lock blocks switching in config 01
// RL8 - PLL lock status bit, read-only
// RL9 - clock fail flag sticky until software clears; code also clears it when a switch starts
// RL10 - switch request reads zero when done
// RL11 - oscillator control writes need unlock sequence
// RL12 - software avoids direct PLL-to-PLL switches
// RL13 - recover-on-interrupt clears reduction enable
// RL14 - reduction field divides by power of two
// RL15 - reduction enable selects ratio else 1:1
// RL16 - fast RC postscaler divides, resets to 1
// RL17 - PLL output divider 2, 4, 8
// RL18 - PLL pre-divider is value plus two
// RL19 - feedback multiplier is value plus two; code's 9-bit output wraps values 510 and 511 to 0 and 1
// RL20 - fast RC trim signed step count
// RL21 - instruction clock is half oscillator output
// RL22 - PLL output is input times M over N1*N2
// RL23 - separate unlock per byte write
// RL24 - wait ten new-source cycles before change
// RL25 - write without unlock is ignored
// RL26 - unimplemented bits read zero
`timescale 1ns/10ps
`include "clkctl_map.svh"
module clock_control (
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_CE,
	input  wire logic        I_POR,
	input  wire logic [2:0]  I_CFG_SOURCE,
	input  wire logic [1:0]  I_CFG_MONITOR,
	input  wire logic        I_PLL_LOCKED,
	input  wire logic        I_CLOCK_FAIL,
	input  wire logic        I_NEW_SRC_READY,
	input  wire logic        I_NEW_SRC_TICK,
	input  wire logic        I_IRQ,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [11:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	input  wire logic [3:0]  I_PSTRB,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	output logic      [2:0]  O_SOURCE_SEL,
	output logic             O_SWITCH_BUSY,
	output logic      [8:0]  O_PLL_MULT,
	output logic      [5:0]  O_PLL_PREDIV,
	output logic      [3:0]  O_PLL_POSTDIV,
	output logic      [8:0]  O_RC_POSTSCALE,
	output logic      [7:0]  O_CPU_DIV,
	output logic      [1:0]  O_CYCLE_DIV,
	output logic      [5:0]  O_RC_TRIM,
	output logic             O_AUX_PLL_EN,
	output logic             O_AUX_SRC_RC,
	output logic      [4:0]  O_AUX_MULT,
	output logic      [2:0]  O_AUX_POSTDIV,
	output logic             O_REF_EN,
	output logic             O_REF_SRC_XTAL,
	output logic      [3:0]  O_REF_DIV
);
	logic [2:0]  cur_src_r;
	logic [2:0]  req_src_r;
	logic        sw_lock_r;
	logic        fail_r;
	logic        sw_req_r;
	logic [15:0] div_r;
	logic [8:0]  fbd_r;
	logic [5:0]  trim_r;
	logic [15:0] aux_r;
	logic [15:0] ref_r;
	logic [3:0]  settle_r;
	logic        por_seen_r;
	clkctl_pkg::sw_state_t sw_state_r;
	clkctl_pkg::unlock_t   unlock_r;

	logic        wr;
	logic        rd;
	logic [15:0] wdat;
	logic        osc_wr_ok;
	logic        hi_wr;
	logic        lo_wr;
	logic        clr_fail;
	logic        sw_start;
	logic        sw_done;
	logic [15:0] osc_word;
	logic [15:0] div_wmask;

	// zero-wait slave: every access completes in its first access cycle
	assign wr = I_PSEL & I_PENABLE & I_PWRITE & I_CE;
	assign rd = I_PSEL & I_PENABLE & ~I_PWRITE;
	assign wdat = I_PWDATA[15:0];
	assign O_PREADY = 1'b1;
	assign div_wmask = `DIV_WMASK;

	assign osc_wr_ok = wr && I_PADDR == `ADDR_OSC_CTRL
		&& unlock_r == clkctl_pkg::UL_OPEN; // [RL11] [RL25]
	// both byte lanes of one write share its unlock; separate byte writes each need their own
	assign hi_wr = osc_wr_ok & I_PSTRB[1]; // [RL23]
	assign lo_wr = osc_wr_ok & I_PSTRB[0];

	// unlock: key1, key2 (or key3 as the second word) opens one write
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			unlock_r <= clkctl_pkg::UL_NONE;
		end else if (I_CE && wr) begin
			unique case (unlock_r)
			clkctl_pkg::UL_NONE:
				if (I_PADDR == `ADDR_UNLOCK && wdat == `UNLOCK_KEY1)
					unlock_r <= clkctl_pkg::UL_ONE;
			clkctl_pkg::UL_ONE:
				if (I_PADDR == `ADDR_UNLOCK && (wdat == `UNLOCK_KEY2
						|| wdat == `UNLOCK_KEY3))
					unlock_r <= clkctl_pkg::UL_OPEN;
				else
					unlock_r <= clkctl_pkg::UL_NONE;
			clkctl_pkg::UL_OPEN:
				unlock_r <= clkctl_pkg::UL_NONE; // [RL11]
			default:
				unlock_r <= clkctl_pkg::UL_NONE;
			endcase
		end
	end

	// source codes: captured from configuration on power-on reset
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			por_seen_r <= 1'b0;
		end else if (I_CE) begin
			por_seen_r <= I_POR;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			cur_src_r <= 3'h0;
			req_src_r <= 3'h0;
		end else if (I_CE) begin
			if (por_seen_r) begin
				cur_src_r <= I_CFG_SOURCE; // [RL6]
				req_src_r <= I_CFG_SOURCE; // [RL6]
			end else begin
				if (sw_done)
					cur_src_r <= req_src_r; // [RL4]
				if (hi_wr)
					req_src_r <= wdat[`OSC_REQ_LSB +: 3]; // [RL5]
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			sw_lock_r <= 1'b0;
		end else if (I_CE && lo_wr) begin
			sw_lock_r <= wdat[`OSC_SWLOCK_BIT];
		end
	end

	// software clears by writing 0 to the bit; a new failure wins
	assign clr_fail = lo_wr & ~wdat[`OSC_FAIL_BIT];
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			fail_r <= 1'b0;
		end else if (I_CE) begin
			if (I_CLOCK_FAIL)
				fail_r <= 1'b1; // [RL9]
			else if (clr_fail || sw_start)
				fail_r <= 1'b0; // [RL9]
		end
	end

	// switching disabled when config bit 1 is set; lock only in 01
	assign sw_start = sw_state_r == clkctl_pkg::SW_IDLE && sw_req_r
		&& req_src_r != cur_src_r && !I_CFG_MONITOR[1]
		&& !(sw_lock_r && I_CFG_MONITOR == `CFG_SW_NO_MON); // [RL7]
	assign sw_done = sw_state_r == clkctl_pkg::SW_DONE;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			sw_req_r <= 1'b0;
		end else if (I_CE) begin
			if (I_CFG_MONITOR[1])
				sw_req_r <= 1'b0;
			else if (lo_wr && wdat[`OSC_SWREQ_BIT])
				sw_req_r <= 1'b1; // [RL10]
			else if (sw_done)
				sw_req_r <= 1'b0; // [RL10]
			else if (sw_state_r == clkctl_pkg::SW_IDLE && sw_req_r
					&& req_src_r == cur_src_r)
				sw_req_r <= 1'b0; // redundant request aborts
		end
	end

	// ready, then count ten ticks of the new source
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			sw_state_r <= clkctl_pkg::SW_IDLE;
			settle_r   <= 4'h0;
		end else if (I_CE) begin
			unique case (sw_state_r)
			clkctl_pkg::SW_IDLE:
				if (sw_start)
					sw_state_r <= clkctl_pkg::SW_WAIT;
			clkctl_pkg::SW_WAIT:
				if (I_NEW_SRC_READY) begin
					settle_r   <= 4'h0;
					sw_state_r <= clkctl_pkg::SW_SETTLE;
				end
			clkctl_pkg::SW_SETTLE:
				if (I_NEW_SRC_TICK) begin
					settle_r <= settle_r + 4'h1;
					if (settle_r == `SWITCH_SETTLE - 4'd1)
						sw_state_r <= clkctl_pkg::SW_DONE; // [RL24]
				end
			clkctl_pkg::SW_DONE:
				sw_state_r <= clkctl_pkg::SW_IDLE;
			default:
				sw_state_r <= clkctl_pkg::SW_IDLE;
			endcase
		end
	end

	// divisor: interrupt recovery clears reduction enable, wins a write
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			div_r <= `DIV_RESET; // [RL14] [RL16] [RL17] [RL18]
		end else if (I_CE) begin
			if (wr && I_PADDR == `ADDR_CLK_DIV) begin
				if (I_PSTRB[1])
					div_r[15:8] <= wdat[15:8] & div_wmask[15:8];
				if (I_PSTRB[0])
					div_r[7:0] <= wdat[7:0] & div_wmask[7:0]; // [RL26]
			end
			if (I_IRQ && div_r[`DIV_ROI_BIT])
				div_r[`DIV_REDEN_BIT] <= 1'b0; // [RL13]
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			fbd_r  <= `FBD_RESET; // [RL19]
			trim_r <= 6'h00;
			aux_r  <= `AUX_RESET;
			ref_r  <= 16'h0000;
		end else if (I_CE && wr) begin
			if (I_PADDR == `ADDR_PLL_FBD)
				fbd_r <= wdat[8:0];
			if (I_PADDR == `ADDR_RC_TUNE)
				trim_r <= wdat[5:0]; // [RL20]
			if (I_PADDR == `ADDR_AUX_CTRL)
				aux_r <= wdat & `AUX_WMASK;
			if (I_PADDR == `ADDR_REF_CTRL)
				ref_r <= wdat & `REF_WMASK;
		end
	end

	assign osc_word = {1'b0, cur_src_r, 1'b0, req_src_r, sw_lock_r,
		1'b0, I_PLL_LOCKED, 1'b0, fail_r, 2'b00, sw_req_r}; // [RL8] [RL26]

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_PRDATA <= 32'h0000_0000;
		end else if (I_CE && I_PSEL && !I_PENABLE && !I_PWRITE) begin
			unique case (I_PADDR)
			`ADDR_OSC_CTRL: O_PRDATA <= {16'h0000, osc_word};
			`ADDR_CLK_DIV:  O_PRDATA <= {16'h0000, div_r};
			`ADDR_PLL_FBD:  O_PRDATA <= {23'h000000, fbd_r};
			`ADDR_RC_TUNE:  O_PRDATA <= {26'h0000000, trim_r};
			`ADDR_AUX_CTRL: O_PRDATA <= {16'h0000, aux_r[15:14],
				aux_r[13:0]} | {17'h00000, I_PLL_LOCKED, 14'h0000};
			`ADDR_REF_CTRL: O_PRDATA <= {16'h0000, ref_r};
			default:        O_PRDATA <= 32'h0000_0000;
			endcase
		end
	end

	assign O_PSLVERR = (rd | (I_PSEL & I_PENABLE & I_PWRITE))
		&& !(I_PADDR == `ADDR_OSC_CTRL || I_PADDR == `ADDR_CLK_DIV
		|| I_PADDR == `ADDR_PLL_FBD || I_PADDR == `ADDR_RC_TUNE
		|| I_PADDR == `ADDR_UNLOCK || I_PADDR == `ADDR_AUX_CTRL
		|| I_PADDR == `ADDR_REF_CTRL);

	// outputs decoded to plain divide factors for the clock tree
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_SOURCE_SEL   <= 3'h0;
			O_SWITCH_BUSY  <= 1'b0;
			O_PLL_MULT     <= 9'h000;
			O_PLL_PREDIV   <= 6'h00;
			O_PLL_POSTDIV  <= 4'h0;
			O_RC_POSTSCALE <= 9'h000;
			O_CPU_DIV      <= 8'h00;
			O_CYCLE_DIV    <= 2'h0;
			O_RC_TRIM      <= 6'h00;
			O_AUX_PLL_EN   <= 1'b0;
			O_AUX_SRC_RC   <= 1'b0;
			O_AUX_MULT     <= 5'h00;
			O_AUX_POSTDIV  <= 3'h0;
			O_REF_EN       <= 1'b0;
			O_REF_SRC_XTAL <= 1'b0;
			O_REF_DIV      <= 4'h0;
		end else if (I_CE) begin
			O_SOURCE_SEL  <= cur_src_r;
			O_SWITCH_BUSY <= sw_state_r != clkctl_pkg::SW_IDLE;
			// multiplier and dividers feed M/(N1*N2)
			O_PLL_MULT   <= fbd_r + 9'h002; // [RL19] [RL22]
			O_PLL_PREDIV <= {1'b0, div_r[4:0]} + 6'h02; // [RL18] [RL22]
			unique case (div_r[7:6])
			2'b00:   O_PLL_POSTDIV <= 4'h2; // [RL17]
			2'b01:   O_PLL_POSTDIV <= 4'h4;
			2'b11:   O_PLL_POSTDIV <= 4'h8;
			default: O_PLL_POSTDIV <= 4'h4; // reserved: hold default
			endcase
			if (div_r[10:8] == 3'h7)
				O_RC_POSTSCALE <= 9'h100; // [RL16]
			else
				O_RC_POSTSCALE <= 9'h001 << div_r[10:8];
			if (div_r[`DIV_REDEN_BIT])
				O_CPU_DIV <= 8'h01 << div_r[14:12]; // [RL14] [RL15]
			else
				O_CPU_DIV <= 8'h01; // [RL15]
			O_CYCLE_DIV    <= 2'h2; // [RL21]
			O_RC_TRIM      <= trim_r; // [RL20]
			O_AUX_PLL_EN   <= aux_r[15];
			O_AUX_SRC_RC   <= aux_r[6]; // [RL2]
			O_AUX_MULT     <= 5'h10; // [RL1]
			O_AUX_POSTDIV  <= aux_r[10:8];
			O_REF_EN       <= ref_r[15];
			O_REF_SRC_XTAL <= ref_r[12]; // [RL3]
			O_REF_DIV      <= ref_r[11:8]; // [RL3]
		end
	end
endmodule : clock_control

// *** dv/clock_control_sva.sv ***
`timescale 1ns/10ps
module clock_control_sva (
	input wire logic        I_CLK,
	input wire logic        I_RST,
	input wire logic        I_PSEL,
	input wire logic        I_PENABLE,
	input wire logic [11:0] I_PADDR,
	input wire logic        O_PREADY,
	input wire logic        O_PSLVERR,
	input wire logic [5:0]  O_PLL_PREDIV,
	input wire logic [3:0]  O_PLL_POSTDIV,
	input wire logic [8:0]  O_RC_POSTSCALE,
	input wire logic [7:0]  O_CPU_DIV,
	input wire logic [1:0]  O_CYCLE_DIV,
	input wire logic [4:0]  O_AUX_MULT
);
	logic [1:0] up_r;
	// decoded outputs settle one edge after release; checks wait two
	always_ff @(posedge I_CLK) begin
		if (I_RST) up_r <= 2'h0;
		else up_r <= {up_r[0], 1'b1};
	end
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	ready_high_a: assert property (O_PREADY)
		else $error("pready low");
	aux_mult_a: assert property (up_r[1] |-> O_AUX_MULT == 5'h10)
		else $error("aux multiplier wrong");
	cycle_div_a: assert property (up_r[1] |-> O_CYCLE_DIV == 2'h2)
		else $error("cycle divide wrong");
	prediv_rng_a: assert property (up_r[1] |->
		O_PLL_PREDIV inside {[6'h02:6'h21]}) else $error("prediv range");
	postdiv_set_a: assert property (up_r[1] |->
		O_PLL_POSTDIV inside {4'h2, 4'h4, 4'h8}) else $error("postdiv value");
	cpu_div_a: assert property (up_r[1] |-> $onehot(O_CPU_DIV))
		else $error("cpu divide not power of two");
	postscale_a: assert property (up_r[1] |-> $onehot(O_RC_POSTSCALE)
		&& O_RC_POSTSCALE != 9'h080) else $error("postscale value");
	unmapped_err_a: assert property (I_PSEL && I_PENABLE
		&& I_PADDR > 12'h018 |-> O_PSLVERR) else $error("no slave error");
	mapped_ok_a: assert property (I_PSEL && I_PENABLE && I_PADDR <= 12'h018
		&& I_PADDR[1:0] == 2'h0 |-> !O_PSLVERR) else $error("false error");
endmodule : clock_control_sva

bind clock_control clock_control_sva chk_i (.I_CLK(I_CLK), .I_RST(I_RST),
	.I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PADDR(I_PADDR),
	.O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_PLL_PREDIV(O_PLL_PREDIV),
	.O_PLL_POSTDIV(O_PLL_POSTDIV), .O_RC_POSTSCALE(O_RC_POSTSCALE),
	.O_CPU_DIV(O_CPU_DIV), .O_CYCLE_DIV(O_CYCLE_DIV), .O_AUX_MULT(O_AUX_MULT));

// *** dv/clock_control_tb.sv ***
`timescale 1ns/10ps
module clock_control_tb;
	logic        clk = 0, rst = 1, por = 0, lk = 0, fail = 0, rdy = 0;
	logic        tk = 0, irq = 0, psel = 0, pen = 0, pwr = 0;
	logic [2:0]  cfg = 3'h2;
	logic [1:0]  mon = 2'h0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0, prd, rv;
	logic [3:0]  pst = 4'h0, post;
	logic        prdy, serr, sv, busy;
	logic [2:0]  sel;
	logic [8:0]  mult, psc;
	logic [5:0]  pre, trim;
	logic [7:0]  cdiv;
	logic        aen, asrc, ren, rxt;
	logic [2:0]  apd;
	logic [3:0]  rdv;
	int          error_cnt = 0, checks = 0;
	always #5 clk = ~clk;
	clock_control dut (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_POR(por),
		.I_CFG_SOURCE(cfg), .I_CFG_MONITOR(mon), .I_PLL_LOCKED(lk),
		.I_CLOCK_FAIL(fail), .I_NEW_SRC_READY(rdy), .I_NEW_SRC_TICK(tk),
		.I_IRQ(irq), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
		.I_PADDR(pa), .I_PWDATA(pwd), .I_PSTRB(pst), .O_PRDATA(prd),
		.O_PREADY(prdy), .O_PSLVERR(serr), .O_SOURCE_SEL(sel),
		.O_SWITCH_BUSY(busy), .O_PLL_MULT(mult), .O_PLL_PREDIV(pre),
		.O_PLL_POSTDIV(post), .O_RC_POSTSCALE(psc), .O_CPU_DIV(cdiv),
		.O_CYCLE_DIV(), .O_RC_TRIM(trim), .O_AUX_PLL_EN(aen),
		.O_AUX_SRC_RC(asrc), .O_AUX_MULT(), .O_AUX_POSTDIV(apd),
		.O_REF_EN(ren), .O_REF_SRC_XTAL(rxt), .O_REF_DIV(rdv));
	task report_and_stop;
		if (error_cnt == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : report_and_stop
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d; pst <= s;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (prdy !== 1'b1 && n < 50);
		if (n >= 50) begin error_cnt++; report_and_stop(); end
		rv = prd;
		sv = serr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask : apb
	task rd(input logic [11:0] a, input string nm, input logic [31:0] e);
		apb(1'b0, a, 32'h0, 4'h0);
		chk(nm, rv, e);
	endtask : rd
	task settle; repeat (2) @(posedge clk); endtask : settle
	// unlock is consumed by the next write, so one per write
	task osc_wr(input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, 12'h010, 32'h46, 4'h1);
		apb(1'b1, 12'h010, 32'h57, 4'h1);
		apb(1'b1, 12'h000, d, s);
	endtask : osc_wr
	task ticks(input int n);
		repeat (n) begin tk <= 1'b1; @(posedge clk); tk <= 1'b0; @(posedge clk); end
	endtask : ticks
	task wait_idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 100) begin @(posedge clk); n++; end
		if (n >= 100) begin error_cnt++; report_and_stop(); end
	endtask : wait_idle
	task t_reset;
		rd(12'h004, "div", 32'h3040);
		rd(12'h008, "fbd", 32'h30);
		rd(12'h00C, "tune", 32'h0);
		chk("mult", mult, 50);
		chk("prediv", pre, 2);
		chk("postdiv", post, 4);
		chk("postsc", psc, 1);
		chk("cpudiv", cdiv, 1);
	endtask : t_reset
	task t_por;
		por <= 1'b1; settle(); por <= 1'b0; lk <= 1'b1; settle();
		rd(12'h000, "osc por", 32'h2220);
		chk("sel", sel, 2);
		apb(1'b1, 12'h000, 32'h0500, 4'h2);
		rd(12'h000, "osc locked", 32'h2220);
		apb(1'b1, 12'h010, 32'h46, 4'h1);
		apb(1'b1, 12'h010, 32'h57, 4'h1);
		apb(1'b1, 12'h00C, 32'h0, 4'h1);
		apb(1'b1, 12'h000, 32'h0500, 4'h2);
		rd(12'h000, "osc relock", 32'h2220);
	endtask : t_por
	task t_switch;
		// sources never jump between the two PLL modes
		osc_wr(32'h0000, 4'h2); rdy <= 1'b1;
		osc_wr(32'h0001, 4'h1);
		// ticks before the settle state is reached would be lost
		settle();
		ticks(9);
		rd(12'h000, "osc wait", 32'h2021);
		ticks(1); wait_idle();
		rd(12'h000, "osc done", 32'h0020);
		settle();
		chk("sel new", sel, 0);
	endtask : t_switch
	task t_lock;
		mon <= 2'h1;
		osc_wr(32'h0080, 4'h1); osc_wr(32'h0200, 4'h2);
		osc_wr(32'h0081, 4'h1); ticks(12); settle();
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk("cur held", rv & 32'h7000, 32'h0);
		osc_wr(32'h0000, 4'h1); osc_wr(32'h0001, 4'h1); ticks(12); wait_idle();
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk("cur moved", rv & 32'h7000, 32'h2000);
	endtask : t_lock
	task t_fail;
		fail <= 1'b1; @(posedge clk); fail <= 1'b0; settle(); settle();
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk("fail set", rv & 32'h8, 32'h8);
		osc_wr(32'h0000, 4'h1);
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk("fail clr", rv & 32'h8, 32'h0);
	endtask : t_fail
	task t_doze;
		apb(1'b1, 12'h004, 32'hA840, 4'h3); settle();
		chk("cpudiv on", cdiv, 4);
		irq <= 1'b1; @(posedge clk); irq <= 1'b0;
		rd(12'h004, "div irq", 32'hA040); settle();
		chk("cpudiv off", cdiv, 1);
		apb(1'b1, 12'h004, 32'h2840, 4'h3);
		irq <= 1'b1; @(posedge clk); irq <= 1'b0;
		rd(12'h004, "div keep", 32'h2840);
	endtask : t_doze
	task t_codes;
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, 12'h004, 32'h40 | (c << 8), 4'h3); settle();
			chk("postsc", psc, c == 7 ? 256 : 1 << c);
		end
		for (int p = 0; p < 4; p++) begin
			apb(1'b1, 12'h004, p << 6, 4'h3); settle();
			chk("postdiv", post, p == 0 ? 2 : (p == 3 ? 8 : 4));
		end
		apb(1'b1, 12'h004, 32'h5F, 4'h3); settle();
		chk("prediv max", pre, 33);
		apb(1'b1, 12'h004, 32'hFFFF, 4'h3);
		rd(12'h004, "div mask", 32'hFFDF); settle();
		chk("cpudiv max", cdiv, 128);
		apb(1'b1, 12'h008, 32'hFFFF, 4'h3);
		rd(12'h008, "fbd mask", 32'h1FF);
		apb(1'b1, 12'h008, 32'h1E, 4'h3); settle();
		chk("mult", mult, 32);
		apb(1'b1, 12'h00C, 32'hFFFF, 4'h3);
		rd(12'h00C, "tune mask", 32'h3F); settle();
		chk("trim", trim, 32'h3F);
		apb(1'b1, 12'h020, 32'hFFFF, 4'h3);
		chk("err wr", sv, 1);
		rd(12'h020, "unmapped", 32'h0);
		chk("err rd", sv, 1);
	endtask : t_codes
	task t_aux;
		// lock status is read-only: a written 1 must not show
		lk <= 1'b0;
		apb(1'b1, 12'h014, 32'hFFFF, 4'h3);
		rd(12'h014, "aux rd", 32'hA7C0);
		settle();
		chk("aux en", aen, 1);
		chk("aux src", asrc, 1);
		chk("aux post", apd, 7);
		apb(1'b1, 12'h014, 32'h0, 4'h3);
		settle();
		chk("aux src off", asrc, 0);
		chk("aux en off", aen, 0);
		apb(1'b1, 12'h018, 32'hFFFF, 4'h3);
		rd(12'h018, "ref rd", 32'hBF00);
		settle();
		chk("ref en", ren, 1);
		chk("ref xtal", rxt, 1);
		chk("ref div", rdv, 4'hF);
		apb(1'b1, 12'h018, 32'h0300, 4'h3);
		settle();
		chk("ref sys", rxt, 0);
		chk("ref div low", rdv, 4'h3);
	endtask : t_aux
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		settle();
		t_reset(); t_por(); t_switch(); t_lock(); t_fail(); t_doze(); t_codes();
		t_aux();
		report_and_stop();
	end
endmodule : clock_control_tb
